// ---- rtl/dog_counter.sv ----
// Watchdog counter with tap compare
`timescale 1ns/1ps
`default_nettype none
module dog_counter
    import dog_timer_pkg::*;
#(
    parameter int unsigned RC_DIV = 20
) (
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Control side
    dog_tick_if.cnt   tk
);
    localparam logic [19:0] LIM0 = 20'(T_SEL0_MS * RC_TICK_PER_MS);
    localparam logic [19:0] LIM1 = 20'(T_SEL1_MS * RC_TICK_PER_MS);
    localparam logic [19:0] LIM2 = 20'(T_SEL2_MS * RC_TICK_PER_MS);
    localparam logic [19:0] LIM3 = 20'(T_SEL3_MS * RC_TICK_PER_MS);

    logic [19:0] cnt_q;
    logic [19:0] limit;

    // Terminal value from the tap currently selected
    function automatic logic [19:0] tap_limit(input logic [1:0] s, input logic xt, input logic sm);
        logic [19:0] r;
        r = 20'h0_0000;
        if (sm) begin
            r = {8'h00, XT_FIXED}; // see R04
        end else if (xt) begin
            unique case (s) // see R02
                2'b00: r = {8'h00, XT_SEL0};
                2'b01: r = {8'h00, XT_SEL1};
                2'b10: r = {8'h00, XT_SEL2};
                2'b11: r = 20'h0_1000;
            endcase
        end else begin
            unique case (s) // see R01
                2'b00: r = LIM0;
                2'b01: r = LIM1;
                2'b10: r = LIM2;
                2'b11: r = LIM3;
            endcase
        end
        return r;
    endfunction : tap_limit

    assign limit = tap_limit(tk.sel, tk.use_xtal, tk.small_variant); // see R16

    // Count ticks, cleared by refresh; sticks at limit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 20'h0_0000;
        end else if (tk.clear) begin
            cnt_q <= 20'h0_0000; // see R16
        end else if (tk.tick && cnt_q < limit) begin
            cnt_q <= cnt_q + 20'h0_0001;
        end
    end

    assign tk.expired = (cnt_q >= limit); // see R16
endmodule : dog_counter
`default_nettype wire

// ---- rtl/dog_tick_if.sv ----
// Interface carrying counter ticks and timeout between top and counter
`timescale 1ns/1ps
`default_nettype none
interface dog_tick_if;
    logic        tick;
    logic        clear;
    logic [1:0]  sel;
    logic        use_xtal;
    logic        small_variant;
    logic        expired;
    modport ctrl (output tick, output clear, output sel, output use_xtal, output small_variant, input expired);
    modport cnt  (input tick, input clear, input sel, input use_xtal, input small_variant, output expired);
endinterface : dog_tick_if
`default_nettype wire

// ---- rtl/dog_timer.sv ----
// Watchdog timer with mode register behind APB
//
// Added by the designer: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module dog_timer
    import dog_timer_pkg::*;
#(
    parameter int unsigned RC_DIV = 20,
    parameter bit          SMALL  = 1'b0
) (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Crystal pin sampled as a clock-rate level
    input  wire logic        crystal_input_pin,
    // Device reset and interrupt
    output logic             dog_reset_req,
    output logic             irq
);
    dog_tick_if tk ();

    logic [7:0]      mode_q;
    logic [6:0]      win_q;
    logic            open_q;
    logic            halt_q, stop_q;
    logic            xtal_prev_q;
    logic [7:0]      rc_div_q;
    logic            rc_tick;
    logic            xtal_tick;
    logic            run_en;
    dog_state_t      st_q;
    logic [EV_W-1:0] ev_q, en_q, ev_set;
    logic            wr, rd, refresh, recover;

    assign wr = psel && penable && pwrite;
    assign rd = psel && penable && !pwrite;
    assign pready = 1'b1;
    assign refresh = wr && paddr == ADDR_CTRL && pwdata[CTRL_REFRESH];
    assign recover = wr && paddr == ADDR_CTRL && pwdata[CTRL_RECOVER];

    // Unmapped addresses answer with an error
    always_comb begin
        unique case (paddr)
            ADDR_MODE, ADDR_CTRL, ADDR_STATUS, ADDR_IRQ_STATUS, ADDR_IRQ_ENABLE, ADDR_IRQ_CLEAR: pslverr = 1'b0;
            default: pslverr = psel && penable;
        endcase
    end

    // Write window of 64 cycles after reset or stop recovery
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            win_q  <= 7'h00;
            open_q <= 1'b1;
        end else if (recover) begin
            win_q  <= 7'h00; // see R14
            open_q <= 1'b1;
        end else if (open_q) begin
            win_q <= win_q + 7'h01;
            if (win_q == 7'(WINDOW_CYCLES - 1)) begin
                open_q <= 1'b0; // see R14
            end
        end
    end

    // Mode register; select bits fixed on the small variant
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= MODE_RESET; // see R03
        end else if (wr && paddr == ADDR_MODE && open_q) begin
            mode_q[SRC_BIT:HALT_BIT] <= pwdata[SRC_BIT:HALT_BIT]; // see R11
            if (!SMALL) begin
                mode_q[1:0] <= pwdata[1:0]; // see R04
            end
        end
    end

    // Low-power mode flags driven by software
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            halt_q <= 1'b0;
            stop_q <= 1'b0;
        end else if (wr && paddr == ADDR_CTRL) begin
            halt_q <= pwdata[CTRL_HALT];
            stop_q <= pwdata[CTRL_STOP] && !pwdata[CTRL_RECOVER];
        end
    end

    // RC tick divider and crystal edge detect
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rc_div_q    <= 8'h00;
            xtal_prev_q <= 1'b0;
        end else begin
            xtal_prev_q <= crystal_input_pin;
            rc_div_q    <= rc_tick ? 8'h00 : rc_div_q + 8'h01;
        end
    end
    assign rc_tick   = rc_div_q == 8'(RC_DIV - 1);
    assign xtal_tick = crystal_input_pin && !xtal_prev_q;

    // Suspend in HALT or STOP unless the activity bit is set; reserved bits ignored
    always_comb begin
        run_en = 1'b1;
        if (halt_q && !mode_q[HALT_BIT]) run_en = 1'b0; // see R06
        if (stop_q && !mode_q[STOP_BIT]) run_en = 1'b0; // see R07
    end

    // Crystal pin clocks the dog when selected; in STOP only while the stop bit is set
    assign tk.use_xtal      = mode_q[SRC_BIT]; // see R10, R09
    assign tk.tick          = st_q == ST_RUN && run_en && (mode_q[SRC_BIT] ? xtal_tick : rc_tick);
    assign tk.sel           = mode_q[1:0];
    assign tk.small_variant = SMALL;
    assign tk.clear         = refresh; // see R16

    // One-shot state; enabled dog is never disabled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= ST_IDLE;
        end else begin
            unique case (st_q)
                ST_IDLE:  if (refresh) st_q <= ST_RUN; // see R12
                ST_RUN:   if (tk.expired && !refresh) st_q <= ST_FIRED; // see R13
                ST_FIRED: st_q <= ST_FIRED;
                default:  st_q <= ST_IDLE;
            endcase
        end
    end

    // Device reset request held after terminal count
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dog_reset_req <= 1'b0;
        end else if (st_q == ST_RUN && tk.expired && !refresh) begin
            dog_reset_req <= 1'b1; // see R12
        end
    end

    // Sticky events; set wins over clear
    always_comb begin
        ev_set = '0;
        ev_set[EV_TIMEOUT] = st_q == ST_RUN && tk.expired && !refresh;
        ev_set[EV_LOCKED]  = open_q && win_q == 7'(WINDOW_CYCLES - 1) && !recover;
        ev_set[EV_REJECT]  = wr && paddr == ADDR_MODE && !open_q;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ev_q <= '0;
            en_q <= '0;
        end else begin
            if (wr && paddr == ADDR_IRQ_ENABLE) en_q <= pwdata[EV_W-1:0];
            ev_q <= ev_set | (ev_q & ~((wr && paddr == ADDR_IRQ_CLEAR) ? pwdata[EV_W-1:0] : '0));
        end
    end

    // Interrupt level output
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) irq <= 1'b0;
        else irq <= |(ev_q & en_q);
    end

    // Read data; the mode register reads as zero
    always_comb begin
        prdata = 32'h0000_0000;
        if (rd) begin
            unique case (paddr)
                ADDR_STATUS:     prdata = {28'h000_0000, open_q, st_q == ST_FIRED, st_q == ST_RUN, run_en};
                ADDR_IRQ_STATUS: prdata = {29'h0000_0000, ev_q};
                ADDR_IRQ_ENABLE: prdata = {29'h0000_0000, en_q};
                default:         prdata = 32'h0000_0000; // see R15
            endcase
        end
    end

    dog_counter #(.RC_DIV(RC_DIV)) u_cnt (
        .pclk    (pclk),
        .presetn (presetn),
        .tk      (tk)
    );
endmodule : dog_timer
`default_nettype wire

// ---- rtl/dog_timer_pkg.sv ----
// Package with register map, field layout, reset values and timing constants
// What this block does
// R01: RC clock taps give 5/15/25/100 ms minimum
// R02: Crystal taps give 256/512/1024/4096 periods
// R03: Select bits reset to code 01
// R04: Small variant fixed at 1024 periods
// R05: Software writes 01 into select on small variant
// R06: Halt bit one keeps counting in HALT
// R07: Stop bit one keeps counting in STOP
// R08: Software picks RC for STOP unless combined case
// R09: Stop and source bits: crystal drives dog only
// R10: Source bit picks RC or crystal pin
// R11: Upper three mode bits reserved, no effect
// R12: Refresh enables then restarts; terminal count resets
// R13: Enabled dog cannot be disabled until reset
// R14: Mode writes accepted only first 64 cycles; code also reopens the 64-cycle window on recover
// R15: Mode register write-only, reads give nothing
// R16: Refresh clears counter; compare uses current tap
package dog_timer_pkg;

    // APB byte addresses; the mode register keeps its index, one aligned word per index
    localparam logic [11:0] IDX_MODE        = 12'h00f;
    localparam logic [11:0] ADDR_MODE       = {IDX_MODE[9:0], 2'b00};
    localparam logic [11:0] ADDR_CTRL       = 12'h010;
    localparam logic [11:0] ADDR_STATUS     = 12'h014;
    localparam logic [11:0] ADDR_IRQ_STATUS = 12'h018;
    localparam logic [11:0] ADDR_IRQ_ENABLE = 12'h01c;
    localparam logic [11:0] ADDR_IRQ_CLEAR  = 12'h020;

    // Mode register fields
    localparam int SEL_LSB    = 0;
    localparam int HALT_BIT   = 2;
    localparam int STOP_BIT   = 3;
    localparam int SRC_BIT    = 4;
    localparam logic [7:0] MODE_RESET = 8'h0d;

    // Control register fields
    localparam int CTRL_REFRESH = 0;
    localparam int CTRL_HALT    = 1;
    localparam int CTRL_STOP    = 2;
    localparam int CTRL_RECOVER = 3;

    // Interrupt event bits
    localparam int EV_TIMEOUT = 0;
    localparam int EV_LOCKED  = 1;
    localparam int EV_REJECT  = 2;
    localparam int EV_W       = 3;

    localparam int unsigned WINDOW_CYCLES = 64;
    localparam int unsigned CNT_W         = 12;

    // RC oscillator nominal rate and tap times
    localparam int unsigned RC_HZ     = 1_000_000;
    localparam int unsigned T_SEL0_MS = 5;
    localparam int unsigned T_SEL1_MS = 15;
    localparam int unsigned T_SEL2_MS = 25;
    localparam int unsigned T_SEL3_MS = 100;
    localparam int unsigned RC_TICK_PER_MS = RC_HZ / 1000;

    // Crystal period counts
    localparam logic [CNT_W-1:0] XT_SEL0  = 12'h0100;
    localparam logic [CNT_W-1:0] XT_SEL1  = 12'h0200;
    localparam logic [CNT_W-1:0] XT_SEL2  = 12'h0400;
    localparam logic [CNT_W-1:0] XT_FIXED = 12'h0400;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_RUN   = 3'b010,
        ST_FIRED = 3'b100
    } dog_state_t;

endpackage : dog_timer_pkg

// ---- verification/dog_timer_props.sv ----
// Concurrent checks on the watchdog bus and reset outputs
`timescale 1ns/1ps
`default_nettype none
module dog_timer_props
    import dog_timer_pkg::*;
(
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // APB slave
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Device reset and interrupt
    input wire logic        dog_reset_req,
    input wire logic        irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Access decode, kept apart so the properties stay short
    logic acc;
    logic mapped;
    assign acc    = psel && penable;
    assign mapped = paddr inside {ADDR_MODE, ADDR_CTRL, ADDR_STATUS, ADDR_IRQ_STATUS, ADDR_IRQ_ENABLE, ADDR_IRQ_CLEAR};

    zero_wait_a: assert property (acc |-> pready)
        else $error("pready low in access");
    mode_unread_a: assert property (acc && !pwrite && paddr == ADDR_MODE |-> prdata == 32'h0000_0000)
        else $error("mode register readable");
    bad_addr_err_a: assert property (acc && !mapped |-> pslverr)
        else $error("unmapped access not refused");
    good_addr_ok_a: assert property (acc && mapped |-> !pslverr)
        else $error("mapped access refused");
    reset_sticks_a: assert property (dog_reset_req |=> dog_reset_req)
        else $error("device reset request dropped");
    refresh_clears_a: assert property (acc && pwrite && paddr == ADDR_CTRL && pwdata[CTRL_REFRESH] && !dog_reset_req
        |=> !dog_reset_req [*8])
        else $error("timeout right after refresh");
    release_quiet_a: assert property ($rose(presetn) |-> !dog_reset_req && !irq)
        else $error("outputs busy after reset");
    irq_masked_a: assert property (acc && pwrite && paddr == ADDR_IRQ_ENABLE && pwdata[EV_W-1:0] == 3'h0
        |-> ##2 !irq)
        else $error("irq high while masked");

    // Main scenarios reached
    cover property ($rose(dog_reset_req));
    cover property (acc && !mapped);
    cover property ($rose(irq));
endmodule : dog_timer_props
bind dog_timer dog_timer_props dog_timer_props_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .dog_reset_req(dog_reset_req), .irq(irq));
`default_nettype wire

// ---- verification/testbench.sv ----
// Self-checking bench for the watchdog: time-outs, suspension, window and interrupts
`timescale 1ns/1ps
`default_nettype none
module testbench import dog_timer_pkg::*;;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, xtal = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic        pready, pslverr, err, rq_b, rq_s, irq;
    int          errors = 0, num_checks = 0;
    logic [31:0] pwdata_small;

    // Small variant always sees select bits written as 01 on a mode write
    assign pwdata_small = (paddr == ADDR_MODE) ? {pwdata[31:2], 2'b01} : pwdata;

    // Full variant and fixed-tap variant share one bus; RC tick every cycle keeps runs short
    dog_timer #(.RC_DIV(1)) dog_timer_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .crystal_input_pin(xtal), .dog_reset_req(rq_b), .irq(irq));
    dog_timer #(.RC_DIV(1), .SMALL(1'b1)) dog_timer_small_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata_small), .prdata(), .pready(), .pslverr(),
        .crystal_input_pin(xtal), .dog_reset_req(rq_s), .irq());

    // Clock, and a crystal with one period every two cycles
    initial begin
        forever #25 pclk = ~pclk;
    end
    always @(posedge pclk) xtal <= ~xtal;

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s exp %0d seen %0d", nm, exp, seen);
        end
    endtask : check

    task automatic test_done;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : test_done

    // One APB transfer; request held until pready is seen at an edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rst;
        presetn <= 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
    endtask : rst

    // Cycles from refresh to device reset, from the tap tables
    function automatic int exp_cyc(input logic [7:0] m, input bit sm);
        int rc[4] = '{5000, 15000, 25000, 100000};
        int xt[4] = '{256, 512, 1024, 4096};
        if (sm)
            return m[SRC_BIT] ? 2048 : 1024;
        return m[SRC_BIT] ? 2 * xt[m[1:0]] : rc[m[1:0]];
    endfunction : exp_cyc

    // A count near the expected one is reported as exact; latency slack is a few cycles
    function automatic int near(input int n, input int e);
        return (e > 0 && n >= e - 6 && n <= e + 12) ? e : n;
    endfunction : near

    // Reset, optional mode write with random reserved bits, refresh, then time the reset request
    task automatic run(input bit wr, input logic [7:0] m, input logic [3:0] ctl, input bit fire);
        int nb, ns, eb, es;
        nb = 0;
        ns = 0;
        eb = fire ? exp_cyc(m, 0) : 0;
        es = fire ? exp_cyc(m, 1) : 0;
        rst();
        if (wr) apb(1'b1, ADDR_MODE, ($urandom() & 32'hffff_ffe0) | 32'(m[4:0]));
        apb(1'b1, ADDR_CTRL, 32'(ctl));
        apb(1'b1, ADDR_CTRL, 32'(ctl & 4'h6));
        for (int c = 1; c <= (fire ? (eb > es ? eb : es) + 100 : 3000); c++) begin
            @(posedge pclk);
            if (rq_b && nb == 0) nb = c;
            if (rq_s && ns == 0) ns = c;
        end
        check("full_timeout", near(nb, eb), eb);
        check("small_timeout", near(ns, es), es);
    endtask : run

    initial begin
        void'($urandom(17));
        rst();
        apb(1'b0, ADDR_MODE, 32'h0);
        check("mode_read", rd, 0);
        apb(1'b0, 12'h100, 32'h0);
        check("unmapped_err", err, 1);
        for (int s = 0; s < 4; s++)
            run(1'b1, 8'h1c | 8'(s), 4'h1, 1'b1);
        run(1'b0, MODE_RESET, 4'h3, 1'b1);
        run(1'b1, 8'h0c, 4'h5, 1'b1);
        run(1'b1, 8'h10, 4'h3, 1'b0);
        run(1'b1, 8'h10, 4'h5, 1'b0);
        run(1'b1, 8'h18, 4'h5, 1'b1);
        // Events: timeout, closed window; mask, unmask, late mode write; then clear
        apb(1'b1, ADDR_IRQ_ENABLE, 32'h0);
        repeat (2) @(posedge pclk);
        check("irq_masked", irq, 0);
        apb(1'b1, ADDR_IRQ_ENABLE, 32'h7);
        repeat (2) @(posedge pclk);
        check("irq_on", irq, 1);
        apb(1'b1, ADDR_MODE, 32'h0);
        apb(1'b0, ADDR_IRQ_STATUS, 32'h0);
        check("events", 32'(rd[2:0]), 7);
        apb(1'b1, ADDR_IRQ_CLEAR, 32'h7);
        repeat (2) @(posedge pclk);
        check("irq_clear", irq, 0);
        test_done();
    end

    // Hang guard, well past the roughly 43k cycles the sequence needs
    initial begin
        #3_000_000;
        errors++;
        test_done();
    end
endmodule : testbench
`default_nettype wire
